//--- rtl/tbss_scheduler.sv
// tdma burst slot scheduler with test signal generator and key watchdog
`timescale 1ns/1ns
// Operation
// - random first slot sets whole schedule
// - other seven slots fixed from first
// - 75 slot spacing, channels alternate
// - active first burst time-out seven, then decrement
// - every slot is an eligible candidate
// - expiry picks one minute plus minus six
// - same time-out within a burst
// - text fifth and sixth at seven, three
// - text messages alternate channels
// - test burst time-out and sub-message zero
// - test mode sends exactly one burst
// - test burst text first and eighth
// - pattern one alternating bits, no encoding
// - pattern two 00001111, no encoding
// - pattern three 511-bit prbs, no encoding
// - ramp up before, ramp down after
// - continuous unmodulated carrier mode
// - edge trigger at transmission reference instant
// - slot grid aligned to two second reference
// - 9600 bps with 24-bit training
// - key held over two seconds shuts down
module tbss_scheduler
  import tbss_pkg::*;
#(
  parameter int unsigned SLOT_CYC   = tbss_pkg::SLOT_CYC_DEF,
  parameter int unsigned BIT_CYC    = tbss_pkg::BIT_CYC_DEF,
  parameter int unsigned KEY_CYC    = tbss_pkg::KEY_LIMIT_CYC,
  parameter logic [7:0]  FRAME_BITS = tbss_pkg::FRAME_BITS_DEF
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // pins from outside the clock domain
  input  wire logic       timeRefPin,
  input  wire logic       activatePin,
  input  wire logic       testModePin,
  input  wire logic       testSigGoPin,
  input  wire logic       carrierReqPin,
  // test pattern choice and frame data from the encoder
  input  wire tbss_pkg::tbss_pat_e testPatSel,
  input  wire logic       frameBitIn,
  // transmitter control
  output logic            txKey_r,
  output logic            rampUp_r,
  output logic            rampDown_r,
  output logic            carrierOnly_r,
  output logic            shutdown_r,
  // bit stream
  output logic            bitOut_r,
  output logic            bitValid_r,
  output logic            encodeBypass_r,
  // message attributes of the current transmission
  output logic            chanB_r,
  output logic            msgIsText_r,
  output logic [2:0]      slotTimeout_r,
  output logic            subMsgZero_r,
  output logic            refTrigger_r,
  output logic            schedActive_r
);
  import tbss_pkg::*;

  if (SLOT_CYC < 2 || BIT_CYC < 2 || KEY_CYC < 2 || FRAME_BITS < 8'h08) begin : g_chk
    $error("tbss_scheduler: parameter out of range");
  end

  typedef enum logic [1:0] {SCH_IDLE, SCH_WAIT, SCH_TX, SCH_DONE} tbss_sch_e;
  typedef enum logic [2:0] {B_IDLE, B_UP, B_TRAIN, B_FRAME, B_DOWN} tbss_bit_e;

  // bring a random word into the slot range without exclusion
  function automatic logic [11:0] modSlots(input logic [11:0] r);
    modSlots = (r >= 12'(SLOTS_PER_MIN)) ? r - 12'(SLOTS_PER_MIN) : r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, stable once stages two and three agree
  logic [4:0] pinS1, pinS2, pinS3, pinStab, pinPrev;
  wire  [4:0] pinRaw = {carrierReqPin, testSigGoPin, testModePin, activatePin, timeRefPin};
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pinS1   <= 5'h00;
      pinS2   <= 5'h00;
      pinS3   <= 5'h00;
      pinStab <= 5'h00;
      pinPrev <= 5'h00;
    end else begin
      pinS1   <= pinRaw;
      pinS2   <= pinS1;
      pinS3   <= pinS2;
      pinStab <= (pinS2 & pinS3) | (pinStab & (pinS2 | pinS3));
      pinPrev <= pinStab;
    end
  end
  wire [4:0] pinRise  = pinStab & ~pinPrev;
  wire       refRise  = pinRise[0];
  wire       actRise  = pinRise[1];
  wire       actLevel = pinStab[1];
  wire       testLvl  = pinStab[2];
  wire       sigGo    = pinRise[3];
  wire       cwLevel  = pinStab[4];

  //////////////////////////////////////////////////////////////////////////////
  // free-running random source
  logic [15:0] rand_r;
  always_ff @(posedge core_clk) begin
    if (!nrst) rand_r <= RAND_SEED;
    else       rand_r <= {rand_r[14:0], rand_r[15] ^ rand_r[13] ^ rand_r[12] ^ rand_r[10]};
  end
  wire [11:0] randSlot = modSlots(rand_r[11:0]);
  wire [8:0]  jitRaw   = rand_r[15:7];
  wire [8:0]  jitSlots = (jitRaw >= JITTER_SPAN) ? jitRaw - JITTER_SPAN : jitRaw;
  wire [11:0] gapJit   = GAP_NOMINAL - JITTER_SLOTS + {3'h0, jitSlots};

  //////////////////////////////////////////////////////////////////////////////
  // slot grid, realigned on each reference mark and free-running between them
  logic [21:0] slotPhase_r;
  wire         slotEnd  = (slotPhase_r == 22'(SLOT_CYC - 1));
  wire         slotTick = slotEnd | refRise;
  always_ff @(posedge core_clk) begin
    if (!nrst || slotTick) slotPhase_r <= 22'h000000;
    else                   slotPhase_r <= slotPhase_r + 22'h000001;
  end

  //////////////////////////////////////////////////////////////////////////////
  // scheduler state
  tbss_sch_e   schState_r, schState_nxt;
  logic [11:0] slotsToGo_r, slotsToGo_nxt;
  logic [2:0]  msgIdx_r, msgIdx_nxt;
  logic [2:0]  timeout_r, timeout_nxt;
  logic        testRun_r, testRun_nxt;
  logic        patRun_r, patRun_nxt;
  tbss_pat_e   pat_r, pat_nxt;
  logic        txGo;
  logic        txDone;

  wire launch  = (schState_r == SCH_WAIT) && slotTick && (slotsToGo_r == 12'h000) && !shutdown_r;
  wire lastMsg = (msgIdx_r == LAST_MSG_IDX);

  // next-state for bursts, test burst and single test signal
  always_comb begin
    schState_nxt  = schState_r;
    slotsToGo_nxt = slotsToGo_r;
    msgIdx_nxt    = msgIdx_r;
    timeout_nxt   = timeout_r;
    testRun_nxt   = testRun_r;
    patRun_nxt    = patRun_r;
    pat_nxt       = pat_r;
    txGo          = 1'b0;
    case (schState_r)
      SCH_IDLE: begin
        if (actRise) begin
          testRun_nxt   = testLvl;
          slotsToGo_nxt = randSlot;
          msgIdx_nxt    = 3'h0;
          timeout_nxt   = testLvl ? TIMEOUT_TEST : TIMEOUT_FIRST;
          schState_nxt  = SCH_WAIT;
        end else if (sigGo && testPatSel != PAT_NONE) begin
          patRun_nxt    = 1'b1;
          pat_nxt       = testPatSel;
          slotsToGo_nxt = 12'h000;
          schState_nxt  = SCH_WAIT;
        end
      end
      SCH_WAIT: begin
        if (launch) begin
          txGo         = 1'b1;
          schState_nxt = SCH_TX;
        end else if (slotTick && slotsToGo_r != 12'h000) begin
          slotsToGo_nxt = slotsToGo_r - 12'h001;
        end
      end
      SCH_TX: begin
        if (txDone) begin
          schState_nxt = SCH_WAIT;
          if (patRun_r) begin
            patRun_nxt   = 1'b0;
            schState_nxt = SCH_IDLE;
          end else if (!lastMsg) begin
            msgIdx_nxt    = msgIdx_r + 3'h1;
            slotsToGo_nxt = SPACING_WAIT;
          end else if (testRun_r) begin
            schState_nxt = SCH_DONE;
          end else begin
            msgIdx_nxt = 3'h0;
            if (timeout_r == 3'h0) begin
              timeout_nxt   = TIMEOUT_FIRST;
              slotsToGo_nxt = gapJit;
            end else begin
              timeout_nxt   = timeout_r - 3'h1;
              slotsToGo_nxt = GAP_NOMINAL;
            end
          end
        end
      end
      SCH_DONE: schState_nxt = SCH_DONE;
      default:  schState_nxt = SCH_IDLE;
    endcase
    if (!actLevel && !patRun_nxt && schState_r != SCH_TX) begin
      schState_nxt = SCH_IDLE;
    end
  end

  // scheduler registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      schState_r  <= SCH_IDLE;
      slotsToGo_r <= 12'h000;
      msgIdx_r    <= 3'h0;
      timeout_r   <= TIMEOUT_FIRST;
      testRun_r   <= 1'b0;
      patRun_r    <= 1'b0;
      pat_r       <= PAT_NONE;
    end else begin
      schState_r  <= schState_nxt;
      slotsToGo_r <= slotsToGo_nxt;
      msgIdx_r    <= msgIdx_nxt;
      timeout_r   <= timeout_nxt;
      testRun_r   <= testRun_nxt;
      patRun_r    <= patRun_nxt;
      pat_r       <= pat_nxt;
    end
  end

  // message placement of the launching transmission
  wire activeText = ((timeout_r == TEXT_TIMEOUT_0) || (timeout_r == TEXT_TIMEOUT_1)) &&
                    ((msgIdx_r == TEXT_IDX_0) || (msgIdx_r == TEXT_IDX_1));
  wire testText   = (msgIdx_r == TEST_TEXT_0) || (msgIdx_r == TEST_TEXT_1);
  wire textNow    = !patRun_r && (testRun_r ? testText : activeText);
  wire chanNow    = !patRun_r && msgIdx_r[0];

  //////////////////////////////////////////////////////////////////////////////
  // bit engine: ramp up, training, frame, ramp down
  tbss_bit_e   bState_r;
  logic [13:0] bitPhase_r;
  logic [7:0]  bitCnt_r;
  logic [2:0]  patCnt_r;
  logic [8:0]  prbs_r;
  wire  bitTick = (bitPhase_r == 14'(BIT_CYC - 1));
  wire  lastBit = bitTick && (bState_r == B_UP    ? bitCnt_r == RAMP_BITS - 8'h01 :
                              bState_r == B_TRAIN ? bitCnt_r == TRAIN_BITS - 8'h01 :
                              bState_r == B_FRAME ? bitCnt_r == FRAME_BITS - 8'h01 :
                              bitCnt_r == RAMP_BITS - 8'h01);
  wire  dataBit = (bState_r == B_TRAIN) || (bState_r == B_FRAME);
  wire  patBit  = (pat_r == PAT_REVERSALS) ? patCnt_r[0] :
                  (pat_r == PAT_QUAD)      ? patCnt_r[2] : prbs_r[8];
  wire  nextBit = patRun_r ? patBit : (bState_r == B_TRAIN) ? bitCnt_r[0] : frameBitIn;
  assign txDone = (bState_r == B_DOWN) && lastBit;

  // bit engine sequencing at 9600 bps
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bState_r   <= B_IDLE;
      bitPhase_r <= 14'h0000;
      bitCnt_r   <= 8'h00;
    end else if (txGo) begin
      bState_r   <= B_UP;
      bitPhase_r <= 14'h0000;
      bitCnt_r   <= 8'h00;
    end else if (bState_r != B_IDLE) begin
      bitPhase_r <= bitTick ? 14'h0000 : bitPhase_r + 14'h0001;
      if (lastBit) begin
        bitCnt_r <= 8'h00;
        case (bState_r)
          B_UP:    bState_r <= B_TRAIN;
          B_TRAIN: bState_r <= B_FRAME;
          B_FRAME: bState_r <= B_DOWN;
          default: bState_r <= B_IDLE;
        endcase
      end else if (bitTick) begin
        bitCnt_r <= bitCnt_r + 8'h01;
      end
    end
  end

  // test pattern generators step once per sent bit
  always_ff @(posedge core_clk) begin
    if (!nrst || txGo) begin
      patCnt_r <= 3'h0;
      prbs_r   <= PRBS_SEED;
    end else if (bitTick && dataBit) begin
      patCnt_r <= patCnt_r + 3'h1;
      prbs_r   <= {prbs_r[7:0], prbs_r[8] ^ prbs_r[4]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // key watchdog, independent of the scheduler
  logic [27:0] keyCnt_r;
  always_ff @(posedge core_clk) begin
    if (!nrst || !txKey_r) keyCnt_r <= 28'h0000000;
    else                   keyCnt_r <= keyCnt_r + 28'h0000001;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      shutdown_r     <= 1'b0;
      txKey_r        <= 1'b0;
      rampUp_r       <= 1'b0;
      rampDown_r     <= 1'b0;
      carrierOnly_r  <= 1'b0;
      bitOut_r       <= 1'b0;
      bitValid_r     <= 1'b0;
      encodeBypass_r <= 1'b0;
      refTrigger_r   <= 1'b0;
      schedActive_r  <= 1'b0;
    end else begin
      shutdown_r     <= shutdown_r || (keyCnt_r >= 28'(KEY_CYC));
      txKey_r        <= !shutdown_r && (txGo || bState_r != B_IDLE || carrierOnly_r);
      rampUp_r       <= !shutdown_r && (txGo || bState_r == B_UP);
      rampDown_r     <= !shutdown_r && (bState_r == B_DOWN);
      carrierOnly_r  <= !shutdown_r && cwLevel && schState_r == SCH_IDLE;
      bitValid_r     <= bitTick && dataBit;
      encodeBypass_r <= patRun_r && (txGo || bState_r != B_IDLE);
      refTrigger_r   <= txGo;
      schedActive_r  <= (schState_r == SCH_WAIT) || (schState_r == SCH_TX);
      if (bitTick && dataBit) bitOut_r <= nextBit;
    end
  end

  // per-transmission attributes, held until the next launch
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      chanB_r       <= 1'b0;
      msgIsText_r   <= 1'b0;
      slotTimeout_r <= 3'h0;
      subMsgZero_r  <= 1'b0;
    end else if (txGo) begin
      chanB_r       <= chanNow;
      msgIsText_r   <= textNow;
      slotTimeout_r <= timeout_r;
      subMsgZero_r  <= testRun_r;
    end
  end
endmodule // tbss_scheduler

//--- rtl/tbss_pkg.sv
// constants for the burst slot scheduler
package tbss_pkg;
  // clock and link timing
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned SLOTS_PER_MIN  = 2250;
  localparam int unsigned MINUTE_S       = 60;
  localparam int unsigned SLOT_CYC_DEF   = 32'((64'(MINUTE_S) * 64'(CLK_HZ)) / 64'(SLOTS_PER_MIN));
  localparam int unsigned BIT_RATE_BPS   = 9600;
  localparam int unsigned BIT_CYC_DEF    = CLK_HZ / BIT_RATE_BPS;
  localparam int unsigned KEY_LIMIT_S    = 2;
  localparam int unsigned KEY_LIMIT_CYC  = KEY_LIMIT_S * CLK_HZ + 1;
  // burst layout
  localparam logic [2:0]  LAST_MSG_IDX   = 3'h7;
  localparam logic [11:0] SLOT_SPACING   = 12'h04B;
  localparam logic [11:0] SPACING_WAIT   = SLOT_SPACING - 12'h001;
  localparam logic [11:0] BURST_SPAN     = 12'h20D;
  localparam logic [11:0] GAP_NOMINAL    = 12'h8CA - BURST_SPAN - 12'h001;
  localparam int unsigned JITTER_S       = 6;
  localparam logic [11:0] JITTER_SLOTS   = 12'(JITTER_S * SLOTS_PER_MIN / MINUTE_S);
  localparam logic [8:0]  JITTER_SPAN    = 9'(2 * JITTER_S * SLOTS_PER_MIN / MINUTE_S + 1);
  // slot time-out values and text message placement
  localparam logic [2:0]  TIMEOUT_FIRST  = 3'h7;
  localparam logic [2:0]  TIMEOUT_TEST   = 3'h0;
  localparam logic [2:0]  TEXT_TIMEOUT_0 = 3'h7;
  localparam logic [2:0]  TEXT_TIMEOUT_1 = 3'h3;
  localparam logic [2:0]  TEXT_IDX_0     = 3'h4;
  localparam logic [2:0]  TEXT_IDX_1     = 3'h5;
  localparam logic [2:0]  TEST_TEXT_0    = 3'h0;
  localparam logic [2:0]  TEST_TEXT_1    = 3'h7;
  // transmission shape in bits
  localparam logic [7:0]  RAMP_BITS      = 8'h08;
  localparam logic [7:0]  TRAIN_BITS     = 8'h18;
  localparam logic [7:0]  FRAME_BITS_DEF = 8'hC8;
  // seeds and test pattern selection
  localparam logic [15:0] RAND_SEED      = 16'hACE1;
  localparam logic [8:0]  PRBS_SEED      = 9'h1FF;
  typedef enum logic [1:0] {PAT_NONE, PAT_REVERSALS, PAT_QUAD, PAT_PRBS} tbss_pat_e;
endpackage

//--- verif/tbss_checker.sv
// assertion checker for the burst slot scheduler
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module tbss_checker #(
  parameter int unsigned BIT_CYC = 8,
  parameter int unsigned KEY_CYC = 50000
) (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // watched outputs
  input wire logic       txKey_r,
  input wire logic       rampUp_r,
  input wire logic       carrierOnly_r,
  input wire logic       shutdown_r,
  input wire logic       bitValid_r,
  input wire logic       msgIsText_r,
  input wire logic [2:0] slotTimeout_r,
  input wire logic       subMsgZero_r,
  input wire logic       refTrigger_r
);
  localparam int RAMP_HI = 8 * BIT_CYC + 1;
  localparam int KEY_MAX = KEY_CYC + 2;
  logic [31:0] keyCnt_r;
  logic [31:0] rampCnt_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // run length of the transmitter key
  always_ff @(posedge core_clk) begin
    if (!nrst || !txKey_r) keyCnt_r <= '0;
    else keyCnt_r <= keyCnt_r + 32'h1;
  end
  // run length of the ramp-up flag, launch cycle included
  always_ff @(posedge core_clk) begin
    if (!nrst || !rampUp_r) rampCnt_r <= '0;
    else rampCnt_r <= rampCnt_r + 32'h1;
  end
  ////////////////////////////////////////////////////////////
  AST_TRIG_PULSE: assert property (refTrigger_r |=> !refTrigger_r)
    else $error("reference trigger longer than one cycle");
  AST_TRIG_KEY: assert property (refTrigger_r |-> txKey_r && rampUp_r)
    else $error("reference trigger without key and ramp");
  AST_RAMP_LEN: assert property ($fell(rampUp_r) && !shutdown_r |-> rampCnt_r == 32'(RAMP_HI))
    else $error("ramp up length wrong");
  AST_TEXT_TIMEOUT: assert property (refTrigger_r && msgIsText_r && !subMsgZero_r
    |-> slotTimeout_r == 3'h7 || slotTimeout_r == 3'h3)
    else $error("text message in wrong burst");
  AST_TEST_ZERO: assert property (refTrigger_r && subMsgZero_r |-> slotTimeout_r == 3'h0)
    else $error("test burst time-out not zero");
  AST_SHUT_KEY: assert property (shutdown_r |=> !txKey_r && !rampUp_r && !refTrigger_r)
    else $error("keyed after shutdown");
  AST_SHUT_STICKY: assert property (shutdown_r |=> shutdown_r)
    else $error("shutdown released");
  AST_KEY_LIMIT: assert property (keyCnt_r <= KEY_MAX)
    else $error("key held beyond limit");
  AST_VALID_PULSE: assert property (bitValid_r |=> !bitValid_r)
    else $error("bit strobe longer than one cycle");
  AST_CARRIER: assert property (carrierOnly_r |-> !bitValid_r && !refTrigger_r)
    else $error("data during carrier mode");
endmodule // tbss_checker

bind tbss_scheduler tbss_checker #(.BIT_CYC(BIT_CYC), .KEY_CYC(KEY_CYC)) tbss_checker_inst (
  .core_clk(core_clk), .nrst(nrst), .txKey_r(txKey_r), .rampUp_r(rampUp_r),
  .carrierOnly_r(carrierOnly_r), .shutdown_r(shutdown_r), .bitValid_r(bitValid_r),
  .msgIsText_r(msgIsText_r), .slotTimeout_r(slotTimeout_r), .subMsgZero_r(subMsgZero_r),
  .refTrigger_r(refTrigger_r));

//--- verif/tbss_radio_model.sv
// modulator and transmitter model recording on-air bits
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module tbss_radio_model (
  // clock and reset
  input wire logic         core_clk,
  input wire logic         nrst,
  // scheduler side
  input wire logic         txKey,
  input wire logic         bitIn,
  input wire logic         bitValid,
  input wire logic         bypass,
  // captured air data
  output logic [7:0]       airCount,
  output logic [63:0]      airBits
);
  logic lineLvl_r;
  logic keyPrev_r;
  // line coding and capture of each keyed bit
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      airCount  <= 8'h00;
      airBits   <= 64'h0;
      lineLvl_r <= 1'b0;
      keyPrev_r <= 1'b0;
    end else begin
      keyPrev_r <= txKey;
      if (txKey && !keyPrev_r) begin
        airCount <= 8'h00;
      end else if (txKey && bitValid) begin
        airBits[airCount[5:0]] <= bypass ? bitIn : (bitIn ? lineLvl_r : ~lineLvl_r);
        if (!bypass && !bitIn) lineLvl_r <= ~lineLvl_r;
        airCount <= airCount + 8'h01;
      end
    end
  end
endmodule // tbss_radio_model

//--- verif/test_tdma_burst_slot_scheduler.sv
// self-checking testbench for the burst slot scheduler
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module test_tdma_burst_slot_scheduler;
  import tbss_pkg::*;
  localparam int unsigned SLOT_CYC   = 112;
  localparam int unsigned BIT_CYC    = 2;
  localparam int unsigned KEY_CYC    = 400;
  localparam logic [7:0]  FRAME_BITS = 8'h08;
  localparam int          LIMIT      = 95000;
  logic       core_clk, nrst, timeRefPin, activatePin, testModePin, testSigGoPin;
  logic       carrierReqPin, frameBitIn, txKey_r, rampUp_r, rampDown_r, carrierOnly_r;
  logic       shutdown_r, bitOut_r, bitValid_r, encodeBypass_r, chanB_r, msgIsText_r;
  logic       subMsgZero_r, refTrigger_r, schedActive_r;
  logic [2:0] slotTimeout_r;
  logic [7:0] airCount;
  logic [63:0] airBits;
  tbss_pat_e  testPatSel;
  logic       fastRef;
  logic [2:0] refCnt;
  int         n_errors, checks, cyc;

  tbss_scheduler #(.SLOT_CYC(SLOT_CYC), .BIT_CYC(BIT_CYC), .KEY_CYC(KEY_CYC),
    .FRAME_BITS(FRAME_BITS)) tbss_scheduler_inst (.core_clk(core_clk), .nrst(nrst),
    .timeRefPin(timeRefPin), .activatePin(activatePin), .testModePin(testModePin),
    .testSigGoPin(testSigGoPin), .carrierReqPin(carrierReqPin), .testPatSel(testPatSel),
    .frameBitIn(frameBitIn), .txKey_r(txKey_r), .rampUp_r(rampUp_r), .rampDown_r(rampDown_r),
    .carrierOnly_r(carrierOnly_r), .shutdown_r(shutdown_r), .bitOut_r(bitOut_r),
    .bitValid_r(bitValid_r), .encodeBypass_r(encodeBypass_r), .chanB_r(chanB_r),
    .msgIsText_r(msgIsText_r), .slotTimeout_r(slotTimeout_r), .subMsgZero_r(subMsgZero_r),
    .refTrigger_r(refTrigger_r), .schedActive_r(schedActive_r));
  tbss_radio_model tbss_radio_model_inst (.core_clk(core_clk), .nrst(nrst), .txKey(txKey_r),
    .bitIn(bitOut_r), .bitValid(bitValid_r), .bypass(encodeBypass_r), .airCount(airCount),
    .airBits(airBits));

  // clock, frame data toggling, compressed reference marks and hang limit
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    frameBitIn <= ~frameBitIn;
    refCnt     <= refCnt + 3'h1;
    timeRefPin <= fastRef && refCnt[2]; // one mark every 8 cycles while enabled
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cmpn(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_trig(input int lim, output logic got);
    got = 1'b0;
    for (int k = 0; k < lim && got !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
      got = refTrigger_r;
    end
  endtask
  task automatic wait_idle(output logic rd);
    rd = 1'b0;
    for (int k = 0; k < 2000 && txKey_r !== 1'b0; k++) begin
      rd = rampDown_r;
      tick(1);
    end
  endtask
  ////////////////////////////////////////////////////////////
  task automatic test_signal(input tbss_pat_e p);
    logic got;
    logic rd;
    int   v4;
    int   v5;
    v4 = 0;
    v5 = 0;
    @(posedge core_clk);
    testPatSel <= p;
    testSigGoPin <= 1'b1;
    tick(8);
    @(posedge core_clk);
    testSigGoPin <= 1'b0;
    wait_trig(3 * SLOT_CYC + 20, got);
    cmp1(got, 1'b1);
    cmp1(rampUp_r, 1'b1);
    cmp1(encodeBypass_r, 1'b1);
    wait_idle(rd);
    cmp1(rd, 1'b1);
    cmpn(32'(airCount), 32'd24 + 32'(FRAME_BITS));
    for (int n = 0; n < 24 + FRAME_BITS; n++) begin
      if (p == PAT_REVERSALS) cmp1(airBits[n], n[0]);
      else if (p == PAT_QUAD) cmp1(airBits[n], n[2]);
      else if (n >= 9) begin
        v5 += int'(airBits[n] !== (airBits[n-9] ^ airBits[n-5]));
        v4 += int'(airBits[n] !== (airBits[n-9] ^ airBits[n-4]));
      end
    end
    if (p == PAT_PRBS) cmp1(v4 == 0 || v5 == 0, 1'b1);
    $display("test signal %0d done", p);
  endtask
  task automatic test_burst();
    logic got;
    int   tp;
    tp = 0;
    fastRef = 1'b1; // fast marks shorten the random first-slot wait
    @(posedge core_clk);
    testModePin <= 1'b1;
    activatePin <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wait_trig(i == 0 ? 2260 * 8 : 75 * SLOT_CYC + 5, got);
      fastRef = 1'b0; // no further mark may realign the grid
      cmp1(got, 1'b1);
      if (i > 0) cmpn(32'(cyc - tp), 32'(75 * SLOT_CYC));
      tp = cyc;
      cmp1(chanB_r, i[0]);
      cmp1(msgIsText_r, i == 0 || i == 7);
      cmpn(32'(slotTimeout_r), 32'(TIMEOUT_TEST));
      cmp1(subMsgZero_r, 1'b1);
    end
    wait_trig(80 * SLOT_CYC, got);
    cmp1(got, 1'b0);
    cmp1(schedActive_r, 1'b0);
    @(posedge core_clk);
    activatePin <= 1'b0;
    testModePin <= 1'b0;
    tick(10);
    $display("test burst done");
  endtask
  task automatic test_carrier();
    @(posedge core_clk);
    carrierReqPin <= 1'b1;
    tick(10);
    cmp1(carrierOnly_r, 1'b1);
    tick(KEY_CYC + 20);
    cmp1(shutdown_r, 1'b1);
    cmp1(txKey_r, 1'b0);
    @(posedge core_clk);
    carrierReqPin <= 1'b0;
    $display("carrier and shutdown done");
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // reset, then the scenarios in turn
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    {timeRefPin, activatePin, testModePin, testSigGoPin, carrierReqPin, frameBitIn} = 6'h00;
    testPatSel = PAT_NONE;
    n_errors = 0;
    checks = 0;
    cyc = 0;
    fastRef = 1'b0;
    refCnt = 3'h0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    tick(4);
    fastRef = 1'b1; // one mark aligns the slot grid
    tick(8);
    fastRef = 1'b0;
    tick(10);
    test_signal(PAT_REVERSALS);
    test_signal(PAT_QUAD);
    test_signal(PAT_PRBS);
    test_burst();
    test_carrier();
    end_sim();
  end
endmodule // test_tdma_burst_slot_scheduler
